// ---- slp_pkg.sv ----
// Shared constants and types of the status indicator sequencer.
// Assumes a single 10 MHz system clock; no module or process lives here.
package slp_pkg;

	// ********************************************************************
	// Time base
	// ********************************************************************
	localparam int CLK_HZ       = 10_000_000;
	localparam int TICK_US      = 1000;
	localparam int MS_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
	localparam int MS_W         = 14;

	// ********************************************************************
	// Pattern phase lengths in milliseconds
	// ********************************************************************
	localparam int DUR_W        = 10;
	localparam logic [DUR_W-1:0] T_FLASH_MS   = 10'd200;
	localparam logic [DUR_W-1:0] T_PAUSE_MS   = 10'd1000;
	localparam logic [DUR_W-1:0] T_TRAFFIC_MS = 10'd50;

	// ********************************************************************
	// Register map, byte addresses
	// ********************************************************************
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam int CTRL_ADAPTER  = 0;
	localparam int CTRL_ENABLE   = 1;
	localparam int CTRL_TO_CLR   = 2;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// ********************************************************************
	// Slave protocol states
	// ********************************************************************
	localparam logic [1:0] ST_INIT   = 2'h0;
	localparam logic [1:0] ST_PREOP  = 2'h1;
	localparam logic [1:0] ST_SAFEOP = 2'h2;
	localparam logic [1:0] ST_OP     = 2'h3;

	typedef enum logic [2:0] {
		PAT_OFF,
		PAT_ON,
		PAT_BLINK,
		PAT_BLINK_INV,
		PAT_SFLASH,
		PAT_DFLASH
	} slp_pat_e;

endpackage

// ---- slp_pattern.sv ----
// One indicator pattern generator driven by a millisecond tick.
// Assumes the tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
module slp_pattern
(
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_tick_ms,
	input  slp_pkg::slp_pat_e     i_pat,
	output logic                  o_lit
);
	slp_pkg::slp_pat_e            pat_q;
	logic [1:0]                   step_q;
	logic [1:0]                   step_d;
	logic [slp_pkg::DUR_W-1:0]    cnt_q;
	logic [slp_pkg::DUR_W-1:0]    cnt_d;
	logic [slp_pkg::DUR_W-1:0]    dur;
	logic [1:0]                   nxt;
	logic                         lit;
	logic                         lit_q;

	always_comb
	begin
		dur = slp_pkg::T_FLASH_MS;
		nxt = 2'h0;
		lit = 1'b0;
		case (pat_q)
			slp_pkg::PAT_ON:
				lit = 1'b1;
			slp_pkg::PAT_BLINK:
			begin
				lit = (step_q == 2'h0);
				nxt = {1'b0, ~step_q[0]};
			end
			slp_pkg::PAT_BLINK_INV:
			begin
				lit = (step_q == 2'h1);
				nxt = {1'b0, ~step_q[0]};
			end
			slp_pkg::PAT_SFLASH:
			begin
				lit = (step_q == 2'h0);
				nxt = {1'b0, ~step_q[0]};
				if (step_q == 2'h1)
					dur = slp_pkg::T_PAUSE_MS;
			end
			slp_pkg::PAT_DFLASH:
			begin
				lit = ~step_q[0];
				nxt = step_q + 2'h1;
				if (step_q == 2'h3)
					dur = slp_pkg::T_PAUSE_MS;
			end
			default:
				lit = 1'b0;
		endcase

		step_d = step_q;
		cnt_d  = cnt_q;
		if (i_pat != pat_q)
		begin
			// A new pattern always starts with its first phase.
			step_d = 2'h0;
			cnt_d  = '0;
		end
		else if (i_tick_ms)
		begin
			if (cnt_q == dur - 10'd1)
			begin
				cnt_d  = '0;
				step_d = nxt;
			end
			else
				cnt_d = cnt_q + 10'd1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			pat_q  <= slp_pkg::PAT_OFF;
			step_q <= 2'h0;
			cnt_q  <= '0;
			lit_q  <= 1'b0;
		end
		else
		begin
			pat_q  <= i_pat;
			step_q <= step_d;
			cnt_q  <= cnt_d;
			lit_q  <= lit;
		end
	end

	assign o_lit = lit_q;
endmodule

// ---- slp_traffic.sv ----
// Activity stretcher for one port: flashes while traffic is seen.
// Assumes i_act is already synchronised to i_mclk.
`timescale 1ns/1ns
module slp_traffic
(
	input  wire logic   i_mclk,
	input  wire logic   i_sys_rst,
	input  wire logic   i_tick_ms,
	input  wire logic   i_act,
	output logic        o_lit,
	output logic        o_busy
);
	logic                       pend_q;
	logic                       pend_d;
	logic                       busy_q;
	logic                       busy_d;
	logic                       lit_q;
	logic                       lit_d;
	logic [slp_pkg::DUR_W-1:0]  cnt_q;
	logic [slp_pkg::DUR_W-1:0]  cnt_d;

	always_comb
	begin
		pend_d = pend_q;
		busy_d = busy_q;
		lit_d  = lit_q;
		cnt_d  = cnt_q;
		if (!busy_q)
		begin
			if (i_act)
			begin
				busy_d = 1'b1;
				lit_d  = 1'b1;
				cnt_d  = '0;
				pend_d = 1'b0;
			end
		end
		else
		begin
			if (i_tick_ms)
			begin
				if (cnt_q == slp_pkg::T_TRAFFIC_MS - 10'd1)
				begin
					cnt_d = '0;
					lit_d = ~lit_q;
					// A flash cycle repeats only if traffic came meanwhile.
					if (!lit_q)
					begin
						busy_d = pend_q;
						lit_d  = pend_q;
						pend_d = 1'b0;
					end
				end
				else
					cnt_d = cnt_q + 10'd1;
			end
			// Traffic seen during a cycle is stretched; set wins.
			if (i_act)
				pend_d = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			pend_q <= 1'b0;
			busy_q <= 1'b0;
			lit_q  <= 1'b0;
			cnt_q  <= '0;
		end
		else
		begin
			pend_q <= pend_d;
			busy_q <= busy_d;
			lit_q  <= lit_d;
			cnt_q  <= cnt_d;
		end
	end

	assign o_lit  = lit_q;
	assign o_busy = busy_q;
endmodule

// ---- slp_top.sv ----
// Status indicator sequencer: maps protocol state onto duo status and
// per-port link and traffic indicators, with a Wishbone register slave.
// Assumes state inputs come from logic on i_mclk; link and traffic
// inputs come from pins and are synchronised here.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module slp_top
#(
	parameter int P_MS_CYCLES = slp_pkg::MS_CYCLES,
	parameter int P_PORTS     = 2
)
(
	input  wire logic                i_mclk,
	input  wire logic                i_sys_rst,
	// Wishbone classic slave.
	input  wire logic                i_wb_cyc,
	input  wire logic                i_wb_stb,
	input  wire logic                i_wb_we,
	input  wire logic [7:0]          i_wb_adr,
	input  wire logic [31:0]         i_wb_dat,
	input  wire logic [3:0]          i_wb_sel,
	output logic      [31:0]         o_wb_dat,
	output logic                     o_wb_ack,
	// Slave protocol state.
	input  wire logic [1:0]          i_slv_state,
	input  wire logic                i_slv_cfg_err,
	input  wire logic                i_slv_local_err,
	input  wire logic                i_slv_pd_wdog,
	// Adapter protocol state.
	input  wire logic                i_self_test,
	input  wire logic                i_ip_valid,
	input  wire logic                i_conn_est,
	input  wire logic                i_dup_ip,
	input  wire logic                i_conn_timeout,
	input  wire logic                i_conn_restored,
	// Port pins.
	input  wire logic [P_PORTS-1:0]  i_link,
	input  wire logic [P_PORTS-1:0]  i_frame_act,
	// Indicators.
	output logic                     o_stat_green,
	output logic                     o_stat_red,
	output logic      [P_PORTS-1:0]  o_link_green,
	output logic      [P_PORTS-1:0]  o_port_traffic_led
);

	// ********************************************************************
	// Millisecond time base
	// ********************************************************************
	logic [slp_pkg::MS_W-1:0]  ms_cnt_q;
	logic [slp_pkg::MS_W-1:0]  ms_cnt_d;
	logic                      tick_q;
	logic                      tick_d;

	always_comb
	begin
		tick_d   = 1'b0;
		ms_cnt_d = ms_cnt_q + 14'd1;
		if (ms_cnt_q == slp_pkg::MS_W'(P_MS_CYCLES - 1))
		begin
			ms_cnt_d = '0;
			tick_d   = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			ms_cnt_q <= '0;
			tick_q   <= 1'b0;
		end
		else
		begin
			ms_cnt_q <= ms_cnt_d;
			tick_q   <= tick_d;
		end
	end

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	logic [P_PORTS-1:0]  link_s1_q;
	logic [P_PORTS-1:0]  link_s2_q;
	logic [P_PORTS-1:0]  act_s1_q;
	logic [P_PORTS-1:0]  act_s2_q;

	always_ff @(posedge i_mclk)
	begin
		link_s1_q <= i_link;
		link_s2_q <= link_s1_q;
		act_s1_q  <= i_frame_act;
		act_s2_q  <= act_s1_q;
	end

	// ********************************************************************
	// Register file
	// ********************************************************************
	logic [1:0]   ctrl_q;
	logic [1:0]   ctrl_d;
	logic         ack_q;
	logic         ack_d;
	logic [31:0]  rdat_q;
	logic [31:0]  rdat_d;
	logic         to_clr;
	logic         wr;
	logic [31:0]  status;

	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;

	always_comb
	begin
		ack_d  = i_wb_cyc && i_wb_stb && !ack_q;
		ctrl_d = ctrl_q;
		to_clr = 1'b0;
		rdat_d = '0;
		if (i_wb_adr == slp_pkg::ADR_CTRL)
		begin
			rdat_d[1:0] = ctrl_q;
			if (wr && i_wb_sel[0])
			begin
				ctrl_d = i_wb_dat[1:0];
				to_clr = i_wb_dat[slp_pkg::CTRL_TO_CLR];
			end
		end
		else if (i_wb_adr == slp_pkg::ADR_STATUS)
			rdat_d = status;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			ctrl_q <= slp_pkg::CTRL_RESET;
			ack_q  <= 1'b0;
			rdat_q <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// ********************************************************************
	// Connection timeout latch
	// ********************************************************************
	logic  to_q;
	logic  to_d;

	// A new timeout in the same cycle as a clear keeps the latch set.
	always_comb
	begin
		to_d = to_q;
		if (i_conn_restored || to_clr)
			to_d = 1'b0;
		if (i_conn_timeout)
			to_d = 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			to_q <= 1'b0;
		else
			to_q <= to_d;
	end

	// ********************************************************************
	// Pattern selection
	// ********************************************************************
	slp_pkg::slp_pat_e  pat_g;
	slp_pkg::slp_pat_e  pat_r;
	logic               adapter;

	assign adapter = ctrl_q[slp_pkg::CTRL_ADAPTER];

	// In slave mode green and red are chosen separately so both may show.
	always_comb
	begin
		pat_g = slp_pkg::PAT_OFF;
		pat_r = slp_pkg::PAT_OFF;
		if (!adapter)
		begin
			case (i_slv_state)
				slp_pkg::ST_PREOP:  pat_g = slp_pkg::PAT_BLINK;
				slp_pkg::ST_SAFEOP: pat_g = slp_pkg::PAT_SFLASH;
				slp_pkg::ST_OP:     pat_g = slp_pkg::PAT_ON;
				default:            pat_g = slp_pkg::PAT_OFF;
			endcase
			if (i_slv_pd_wdog)
				pat_r = slp_pkg::PAT_DFLASH;
			else if (i_slv_local_err)
				pat_r = slp_pkg::PAT_SFLASH;
			else if (i_slv_cfg_err)
				pat_r = slp_pkg::PAT_BLINK;
		end
		else if (i_self_test)
		begin
			pat_g = slp_pkg::PAT_BLINK;
			pat_r = slp_pkg::PAT_BLINK_INV;
		end
		else if (!i_ip_valid)
			pat_r = slp_pkg::PAT_OFF;
		else if (i_dup_ip)
			pat_r = slp_pkg::PAT_ON;
		else if (to_q)
			pat_r = slp_pkg::PAT_BLINK;
		else if (i_conn_est)
			pat_g = slp_pkg::PAT_ON;
		else
			pat_g = slp_pkg::PAT_BLINK;
	end

	logic  g_lit;
	logic  r_lit;

	slp_pattern u_green
	(
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_tick_ms (tick_q),
		.i_pat     (pat_g),
		.o_lit     (g_lit)
	);

	slp_pattern u_red
	(
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_tick_ms (tick_q),
		.i_pat     (pat_r),
		.o_lit     (r_lit)
	);

	// ********************************************************************
	// Per-port traffic
	// ********************************************************************
	logic [P_PORTS-1:0]  tr_lit;
	logic [P_PORTS-1:0]  tr_busy;

	for (genvar p = 0; p < P_PORTS; p++)
	begin : g_port
		slp_traffic u_traffic
		(
			.i_mclk    (i_mclk),
			.i_sys_rst (i_sys_rst),
			.i_tick_ms (tick_q),
			.i_act     (act_s2_q[p] & link_s2_q[p]),
			.o_lit     (tr_lit[p]),
			.o_busy    (tr_busy[p])
		);
	end

	// ********************************************************************
	// Output stage
	// ********************************************************************
	logic                en;
	logic                green_q;
	logic                green_d;
	logic                red_q;
	logic                red_d;
	logic [P_PORTS-1:0]  link_q;
	logic [P_PORTS-1:0]  link_d;
	logic [P_PORTS-1:0]  yel_q;
	logic [P_PORTS-1:0]  yel_d;

	assign en = ctrl_q[slp_pkg::CTRL_ENABLE];

	always_comb
	begin
		green_d = en & g_lit;
		red_d   = en & r_lit;
		if (adapter)
		begin
			link_d = link_s2_q;
			yel_d  = tr_lit;
		end
		else
		begin
			// Steady with link, the flash replaces it during traffic.
			link_d = link_s2_q & (~tr_busy | tr_lit);
			yel_d  = '0;
		end
		if (!en)
		begin
			link_d = '0;
			yel_d  = '0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			green_q <= 1'b0;
			red_q   <= 1'b0;
			link_q  <= '0;
			yel_q   <= '0;
		end
		else
		begin
			green_q <= green_d;
			red_q   <= red_d;
			link_q  <= link_d;
			yel_q   <= yel_d;
		end
	end

	assign status = {10'h0, link_s2_q[1:0], yel_q[1:0], link_q[1:0], 5'h0,
		pat_r, 1'b0, pat_g, 1'b0, to_q, red_q, green_q};

	assign o_wb_dat           = rdat_q;
	assign o_wb_ack           = ack_q;
	assign o_stat_green       = green_q;
	assign o_stat_red         = red_q;
	assign o_link_green       = link_q;
	assign o_port_traffic_led = yel_q;
endmodule

// ---- slp_top_assertions.sv ----
// Port-level checks of the status indicator sequencer.
// Assumes a master that holds each Wishbone request until ack.
`timescale 1ns/1ns
module slp_top_checker
#(
	parameter int P_MS_CYCLES = slp_pkg::MS_CYCLES,
	parameter int P_PORTS     = 2
)
(
	input  wire logic               i_mclk,
	input  wire logic               i_sys_rst,
	input  wire logic               i_wb_cyc,
	input  wire logic               i_wb_stb,
	input  wire logic               i_wb_we,
	input  wire logic [7:0]         i_wb_adr,
	input  wire logic [31:0]        i_wb_dat,
	input  wire logic [3:0]         i_wb_sel,
	input  wire logic               o_wb_ack,
	input  wire logic [1:0]         i_slv_state,
	input  wire logic               i_self_test,
	input  wire logic               i_ip_valid,
	input  wire logic               i_dup_ip,
	input  wire logic [P_PORTS-1:0] i_link,
	input  wire logic               o_stat_green,
	input  wire logic               o_stat_red,
	input  wire logic [P_PORTS-1:0] o_link_green,
	input  wire logic [P_PORTS-1:0] o_port_traffic_led
);
	// Mode is snooped from bus writes; calm counts cycles since one, so
	// that the output pipeline has settled before a check applies.
	logic       mode_q, mode_d, en_q, en_d, wr_ctrl, calm;
	logic [2:0] calm_q, calm_d;
	assign wr_ctrl = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0]
		& (i_wb_adr == slp_pkg::ADR_CTRL);
	assign calm = (calm_q == 3'h7);
	always_comb
	begin
		mode_d = wr_ctrl ? i_wb_dat[0] : mode_q;
		en_d = wr_ctrl ? i_wb_dat[1] : en_q;
		calm_d = wr_ctrl ? 3'h0 : (calm ? calm_q : calm_q + 3'h1);
		if (i_sys_rst)
		begin
			mode_d = 1'b0;
			en_d = 1'b1;
			calm_d = 3'h0;
		end
	end
	always_ff @(posedge i_mclk)
	begin
		mode_q <= mode_d;
		en_q <= en_d;
		calm_q <= calm_d;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_dup;
		calm && mode_q && en_q && i_ip_valid && i_dup_ip && !i_self_test;
	endsequence
	sequence s_selftest;
		calm && mode_q && i_self_test;
	endsequence
	chk_selftest_alt: assert property (s_selftest [*3] |->
		!(o_stat_green && o_stat_red))
		else $error("self-test green and red lit together");
	chk_ack_answer: assert property (s_req |=> o_wb_ack)
		else $error("ack missing one cycle after request");
	chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_yellow_slave: assert property (
		calm && !mode_q |-> o_port_traffic_led == '0)
		else $error("yellow lit in slave mode");
	chk_dark_off: assert property (calm && !en_q |-> !o_stat_green
		&& !o_stat_red && o_link_green == '0 && o_port_traffic_led == '0)
		else $error("indicator lit while disabled");
	chk_link_lost: assert property (
		(!i_link[0]) [*5] |-> !o_link_green[0])
		else $error("link led lit without link");
	chk_dup_red: assert property (s_dup [*5] |-> o_stat_red)
		else $error("duplicate address not steady red");
	chk_noip_dark: assert property (
		(calm && mode_q && !i_ip_valid && !i_self_test) [*5]
		|-> !o_stat_green && !o_stat_red)
		else $error("status lit without address");
	chk_op_green: assert property (
		(calm && !mode_q && en_q && i_slv_state == slp_pkg::ST_OP) [*5]
		|-> o_stat_green)
		else $error("operational green not steady");
	chk_init_dark: assert property (
		(calm && !mode_q && i_slv_state == slp_pkg::ST_INIT) [*5]
		|-> !o_stat_green)
		else $error("green lit in init state");
endmodule
bind slp_top slp_top_checker #(.P_MS_CYCLES(P_MS_CYCLES), .P_PORTS(P_PORTS))
	u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_ack(o_wb_ack),
	.i_slv_state(i_slv_state), .i_self_test(i_self_test),
	.i_ip_valid(i_ip_valid), .i_dup_ip(i_dup_ip), .i_link(i_link),
	.o_stat_green(o_stat_green), .o_stat_red(o_stat_red),
	.o_link_green(o_link_green), .o_port_traffic_led(o_port_traffic_led));

// ---- slp_led_meter.sv ----
// Observer standing in for one indicator: last lit and dark run lengths.
// Assumes the indicator is sampled on the system clock.
`timescale 1ns/1ns
module slp_led_meter
(
	input  wire logic        i_mclk,
	input  wire logic        i_led,
	output logic      [15:0] o_on_len,
	output logic      [15:0] o_off_len
);
	logic        prev;
	logic [15:0] run;
	initial
	begin
		prev = 1'b0;
		run = 16'h0;
		o_on_len = 16'h0;
		o_off_len = 16'h0;
	end
	always @(posedge i_mclk)
	begin
		if (i_led !== prev)
		begin
			if (prev) o_on_len <= run;
			else o_off_len <= run;
			run <= 16'h1;
		end
		else run <= run + 16'h1;
		prev <= i_led;
	end
endmodule

// ---- slp_top_tb_top.sv ----
// Self-checking bench of the sequencer through its bus and state pins.
// Assumes a 10 cycle millisecond tick, so 200 ms is 2000 cycles.
`timescale 1ns/1ns
module slp_top_tb_top;
	localparam int MS = 10;
	logic        clk, rst, cyc, stb, we, ack, cfg, lerr, wdog, tst;
	logic        ipv, est, dup, tmo, rsto, grn, red;
	logic [7:0]  adr;
	logic [31:0] wd, rdat, q;
	logic [1:0]  st, lnk, act, lg, yl;
	logic [15:0] gon, goff, ron, roff;
	logic [2:0]  gx [4];
	int          mismatches, total_checks;
	slp_top #(.P_MS_CYCLES(MS), .P_PORTS(2)) uut (.i_mclk(clk),
		.i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hf), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_slv_state(st), .i_slv_cfg_err(cfg),
		.i_slv_local_err(lerr), .i_slv_pd_wdog(wdog), .i_self_test(tst),
		.i_ip_valid(ipv), .i_conn_est(est), .i_dup_ip(dup),
		.i_conn_timeout(tmo), .i_conn_restored(rsto), .i_link(lnk),
		.i_frame_act(act), .o_stat_green(grn), .o_stat_red(red),
		.o_link_green(lg), .o_port_traffic_led(yl));
	slp_led_meter u_mg (.i_mclk(clk), .i_led(grn), .o_on_len(gon),
		.o_off_len(goff));
	slp_led_meter u_mr (.i_mclk(clk), .i_led(red), .o_on_len(ron),
		.o_off_len(roff));
	// *****************************************************************
	// Tasks
	// *****************************************************************
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// A green code of 7 means the green field is not compared.
	task automatic pats(input logic [2:0] g, input logic [2:0] r);
		tick(5);
		wb(slp_pkg::ADR_STATUS, 1'b0, 32'h0);
		if (g != 3'h7) check("green pattern", {29'h0, q[6:4]}, {29'h0, g});
		check("red pattern", {29'h0, q[10:8]}, {29'h0, r});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#6_000_000;
		mismatches++;
		conclude();
	end
	// *****************************************************************
	// Main sequence
	// *****************************************************************
	initial
	begin
		{rst, cyc, stb, we, adr, wd, st, lnk, act} = {1'b1, 49'h0};
		{cfg, lerr, wdog, tst, ipv, est, dup, tmo, rsto} = 9'h0;
		{mismatches, total_checks} = '0;
		gx = '{slp_pkg::PAT_OFF, slp_pkg::PAT_BLINK, slp_pkg::PAT_SFLASH,
			slp_pkg::PAT_ON};
		tick(2);
		rst <= 1'b0;
		wb(slp_pkg::ADR_CTRL, 1'b0, 32'h0);
		check("ctrl reset", q, 32'h2);
		wb(8'h08, 1'b1, 32'hff);
		wb(8'h08, 1'b0, 32'h0);
		check("unmapped read", q, 32'h0);
		wb(slp_pkg::ADR_STATUS, 1'b0, 32'h0);
		check("status reset", q, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) st <= 2'(i);
			pats(gx[i], slp_pkg::PAT_OFF);
		end
		@(posedge clk) st <= slp_pkg::ST_PREOP;
		tick(7000);
		check("blink lit", 32'(gon), 200 * MS);
		check("blink dark", 32'(goff), 200 * MS);
		@(posedge clk) {st, cfg} <= {slp_pkg::ST_OP, 1'b1};
		pats(slp_pkg::PAT_ON, slp_pkg::PAT_BLINK);
		@(posedge clk) lerr <= 1'b1;
		tick(15000);
		check("single lit", 32'(ron), 200 * MS);
		check("single dark", 32'(roff), 1000 * MS);
		pats(slp_pkg::PAT_ON, slp_pkg::PAT_SFLASH);
		@(posedge clk) {st, wdog} <= {slp_pkg::ST_SAFEOP, 1'b1};
		tick(19000);
		check("double lit", 32'(ron), 200 * MS);
		check("double dark", 32'(roff), 1000 * MS);
		check("green single dark", 32'(goff), 1000 * MS);
		pats(slp_pkg::PAT_SFLASH, slp_pkg::PAT_DFLASH);
		@(posedge clk) {cfg, lerr, wdog, lnk} <= 5'h01;
		tick(8);
		check("slave link", 32'(lg), 32'h1);
		@(posedge clk) act <= 2'h3;
		@(posedge clk) act <= 2'h0;
		tick(700);
		check("slave traffic", 32'(lg), 32'h0);
		check("slave yellow", 32'(yl), 32'h0);
		wb(slp_pkg::ADR_CTRL, 1'b1, 32'h3);
		@(posedge clk) tst <= 1'b1;
		pats(slp_pkg::PAT_BLINK, slp_pkg::PAT_BLINK_INV);
		tick(2500);
		check("self-test alternate", {30'h0, grn, red}, 32'h1);
		@(posedge clk) tst <= 1'b0;
		pats(slp_pkg::PAT_OFF, slp_pkg::PAT_OFF);
		@(posedge clk) {ipv, dup} <= 2'h3;
		pats(3'h7, slp_pkg::PAT_ON);
		@(posedge clk) {dup, tmo} <= 2'h1;
		@(posedge clk) {tmo, est} <= 2'h1;
		pats(slp_pkg::PAT_OFF, slp_pkg::PAT_BLINK);
		check("timeout latch", {31'h0, q[2]}, 32'h1);
		@(posedge clk) rsto <= 1'b1;
		@(posedge clk) rsto <= 1'b0;
		pats(slp_pkg::PAT_ON, slp_pkg::PAT_OFF);
		@(posedge clk) tmo <= 1'b1;
		@(posedge clk) tmo <= 1'b0;
		wb(slp_pkg::ADR_CTRL, 1'b1, 32'h7);
		wb(slp_pkg::ADR_CTRL, 1'b0, 32'h0);
		check("ctrl clear bit", q, 32'h3);
		@(posedge clk) est <= 1'b0;
		pats(slp_pkg::PAT_BLINK, slp_pkg::PAT_OFF);
		check("adapter link", 32'(lg), 32'h1);
		@(posedge clk) act <= 2'h3;
		@(posedge clk) act <= 2'h0;
		tick(20);
		check("adapter yellow", 32'(yl), 32'h1);
		tick(700);
		check("yellow dark phase", 32'(yl), 32'h0);
		wb(slp_pkg::ADR_CTRL, 1'b1, 32'h0);
		tick(10);
		check("disabled", {26'h0, grn, red, lg, yl}, 32'h0);
		conclude();
	end
endmodule
